//--- design/utrbd_top.sv
// Operation
// - divide by sixteen-bit divisor, one to max
// - sixteen ticks of sampling clock per bit
// - each bit lasts sixteen ticks, shifter steps
// - start, data, optional parity, stop bits
// - data leaves least significant bit first
// - holding write pushes into transmit fifo
// - holding empty set on move to shifter
// - holding empty raises enabled transmit interrupt
// - transmitter empty once shifter fully drained
// - fifo mode: holding empty when fifo empty
// - fifo mode: empty needs fifo and shifter
// - falling edge, eight ticks, confirm start low
// - later bits sampled centred, sixteen ticks apart
// - parity, framing, break shown in status
// - receive fifo sixteen entries of eleven bits
// - holding read pops, tags follow new head
// - holding register shows oldest character
// - data interrupt per character or trigger
// - fifo mode: timeout after four words plus twelve bits
// - receive interrupts need enable bit zero
`timescale 1ns/1ps
module utrbd_top
  import utrbd_pkg::*;
#(
  parameter int TX_DEPTH = 16,
  parameter int RX_DEPTH = 16
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // host register port
  input  wire logic [2:0] addr,
  input  wire logic       wrStrobe,
  input  wire logic       rdStrobe,
  input  wire logic [7:0] wrData,
  output logic      [7:0] rdData,
  // serial line and interrupt
  input  wire logic       rxd,
  output logic            txd,
  output logic            irq
);
  localparam int TW = $clog2(TX_DEPTH);
  localparam int RW = $clog2(RX_DEPTH);
  localparam logic [TW:0] TX_FULL = (TW+1)'(TX_DEPTH);
  localparam logic [RW:0] RX_FULL = (RW+1)'(RX_DEPTH);

  // parity bit from running xor of the data bits
  function automatic logic parBit(input logic [7:0] lc, input logic acc);
    if (lc[LCTL_STICK]) parBit = !lc[LCTL_EVEN];
    else parBit = lc[LCTL_EVEN] ? acc : !acc;
  endfunction

  logic [7:0]  lctl_q, ien_q, fctl_q, rdData_q;
  logic [15:0] div_q, baudCnt_q;
  logic        txd_q, irq_q, ovr_q, tmo_q;

  // register decode; divisor latch shadows offsets zero and one
  wire dlab   = lctl_q[LCTL_DLAB];
  wire fifoEn = fctl_q[FCTL_EN];
  wire wrHold = wrStrobe && addr == ADDR_HOLD && !dlab;
  wire rdHold = rdStrobe && addr == ADDR_HOLD && !dlab;
  wire wrDivL = wrStrobe && addr == ADDR_HOLD && dlab;
  wire wrDivH = wrStrobe && addr == ADDR_IEN && dlab;
  wire wrIen  = wrStrobe && addr == ADDR_IEN && !dlab;
  wire wrFctl = wrStrobe && addr == ADDR_IFC;
  wire wrLctl = wrStrobe && addr == ADDR_LCTL;
  wire rdLsts = rdStrobe && addr == ADDR_LSTS;
  // toggling fifo mode also flushes, so stale depth never leaks over
  wire modeChg = wrFctl && wrData[FCTL_EN] != fifoEn;
  wire txRst  = wrFctl && (wrData[FCTL_TXRST] || modeChg);
  wire rxRst  = wrFctl && (wrData[FCTL_RXRST] || modeChg);

  // control registers
  always_ff @(posedge clk) begin
    if (rst) begin
      lctl_q <= LCTL_RST;
      ien_q  <= IEN_RST;
      fctl_q <= FCTL_RST;
      div_q  <= DIV_RST;
    end else begin
      if (wrLctl) lctl_q <= wrData;
      if (wrIen) ien_q <= {4'h0, wrData[3:0]};
      if (wrFctl) fctl_q <= {wrData[7:6], 2'b00, wrData[3], 2'b00, wrData[0]};
      if (wrDivL) div_q[7:0] <= wrData;
      if (wrDivH) div_q[15:8] <= wrData;
    end
  end

  // sampling tick; a zero divisor is treated as one
  wire [15:0] divM1 = (div_q == 16'h0000) ? 16'h0000 : div_q - 16'h0001;
  wire tick = baudCnt_q >= divM1;
  always_ff @(posedge clk) begin
    if (rst || wrDivL || wrDivH || tick) baudCnt_q <= 16'h0000;
    else baudCnt_q <= baudCnt_q + 16'h0001;
  end

  // transmit fifo; depth one without fifo mode
  logic [7:0]  txMem [TX_DEPTH];
  logic [TW-1:0] txWr_q, txRd_q;
  logic [TW:0] txCnt_q;
  utrbd_tx_e   txState_q;
  logic [3:0]  txTk_q;
  logic [2:0]  txBit_q;
  logic [7:0]  txSh_q;
  logic        txPar_q, txStop_q;
  wire [TW:0] txLimit = fifoEn ? TX_FULL : (TW+1)'(1);
  wire txFull = txCnt_q >= txLimit;
  wire txPush = wrHold && !txFull;
  // load only on a tick so the start bit gets all sixteen ticks
  wire txPop  = txState_q == TX_IDLE && txCnt_q != '0 && !txRst && tick;
  always_ff @(posedge clk) begin
    if (txPush) txMem[txWr_q] <= wrData;
  end
  always_ff @(posedge clk) begin
    if (rst || txRst) begin
      txWr_q  <= '0;
      txRd_q  <= '0;
      txCnt_q <= '0;
    end else begin
      if (txPush) txWr_q <= txWr_q + TW'(1);
      if (txPop) txRd_q <= txRd_q + TW'(1);
      txCnt_q <= txCnt_q + (TW+1)'(txPush) - (TW+1)'(txPop);
    end
  end

  // transmit shifter
  wire [2:0] dataLast = 3'(WL_BASE - 1) + {1'b0, lctl_q[1:0]};
  wire txBitEnd = tick && txTk_q == BIT_LAST;
  always_ff @(posedge clk) begin
    if (rst || txState_q == TX_IDLE) txTk_q <= 4'h0;
    else if (tick) txTk_q <= txTk_q + 4'h1;
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      txState_q <= TX_IDLE;
      txBit_q   <= 3'h0;
      txSh_q    <= 8'h00;
      txPar_q   <= 1'b0;
      txStop_q  <= 1'b0;
    end else begin
      case (txState_q)
        TX_IDLE: if (txPop) begin
          txState_q <= TX_START;
          txSh_q    <= txMem[txRd_q];
          txPar_q   <= 1'b0;
        end
        TX_START: if (txBitEnd) begin
          txState_q <= TX_DATA;
          txBit_q   <= 3'h0;
        end
        TX_DATA: if (txBitEnd) begin
          txSh_q   <= {1'b0, txSh_q[7:1]};
          txPar_q  <= txPar_q ^ txSh_q[0];
          txBit_q  <= txBit_q + 3'h1;
          txStop_q <= lctl_q[LCTL_STOP];
          if (txBit_q == dataLast)
            txState_q <= lctl_q[LCTL_PEN] ? TX_PAR : TX_STOP;
        end
        TX_PAR: if (txBitEnd) txState_q <= TX_STOP;
        TX_STOP: if (txBitEnd) begin
          if (txStop_q) txStop_q <= 1'b0;
          else txState_q <= TX_IDLE;
        end
        default: txState_q <= TX_IDLE;
      endcase
    end
  end
  wire txLine = lctl_q[LCTL_BRK] ? 1'b0 :
                txState_q == TX_START ? 1'b0 :
                txState_q == TX_DATA ? txSh_q[0] :
                txState_q == TX_PAR ? parBit(lctl_q, txPar_q) : 1'b1;
  // holding empty once byte left; fifo empty
  wire thre = txCnt_q == '0;
  wire temt = thre && txState_q == TX_IDLE;

  // receive line synchroniser and edge
  logic rxS1_q, rxS2_q, rxPrev_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      rxS1_q   <= 1'b1;
      rxS2_q   <= 1'b1;
      rxPrev_q <= 1'b1;
    end else begin
      rxS1_q   <= rxd;
      rxS2_q   <= rxS1_q;
      rxPrev_q <= rxS2_q;
    end
  end
  wire rxFall = rxPrev_q && !rxS2_q;

  // receive shifter
  utrbd_rx_e rxState_q;
  logic [3:0] rxTk_q;
  logic [2:0] rxBit_q;
  logic [7:0] rxSh_q;
  logic       rxPar_q, rxPerr_q;
  wire rxSamp = tick && rxTk_q == SAMPLE_AT;
  wire rxStore = rxState_q == RX_STOP && rxSamp;
  wire [7:0] rxAlign = rxSh_q >> (3'h3 - {1'b0, lctl_q[1:0]});
  always_ff @(posedge clk) begin
    if (rst || rxState_q == RX_IDLE) rxTk_q <= 4'h0;
    else if (tick) rxTk_q <= rxTk_q + 4'h1;
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      rxState_q <= RX_IDLE;
      rxBit_q   <= 3'h0;
      rxSh_q    <= 8'h00;
      rxPar_q   <= 1'b0;
      rxPerr_q  <= 1'b0;
    end else begin
      case (rxState_q)
        RX_IDLE: if (rxFall) rxState_q <= RX_START;
        RX_START: if (rxSamp) begin
          rxState_q <= rxS2_q ? RX_IDLE : RX_DATA;
          rxBit_q   <= 3'h0;
          rxPar_q   <= 1'b0;
          rxPerr_q  <= 1'b0;
        end
        RX_DATA: if (rxSamp) begin
          rxSh_q  <= {rxS2_q, rxSh_q[7:1]};
          rxPar_q <= rxPar_q ^ rxS2_q;
          rxBit_q <= rxBit_q + 3'h1;
          if (rxBit_q == dataLast)
            rxState_q <= lctl_q[LCTL_PEN] ? RX_PAR : RX_STOP;
        end
        RX_PAR: if (rxSamp) begin
          rxPerr_q  <= rxS2_q != parBit(lctl_q, rxPar_q);
          rxState_q <= RX_STOP;
        end
        RX_STOP: if (rxSamp) rxState_q <= RX_IDLE;
        default: rxState_q <= RX_IDLE;
      endcase
    end
  end
  utrbd_rx_s rxWord;
  assign rxWord = '{brk: !rxS2_q && rxAlign == 8'h00, frm: !rxS2_q,
                    par: rxPerr_q, data: rxAlign};

  // two-entry buffer ahead of the fifo; when it fills, words overrun
  utrbd_rx_s  skMem [2];
  logic       skWr_q, skRd_q;
  logic [1:0] skCnt_q;
  wire skInReady = skCnt_q != 2'h2;
  wire skOutValid = skCnt_q != 2'h0;
  wire skIn = rxStore && skInReady;
  logic [RW:0] rxCnt_q;
  wire [RW:0] rxLimit = fifoEn ? RX_FULL : (RW+1)'(1);
  wire rxFull = rxCnt_q >= rxLimit;
  wire skOut = skOutValid && !rxFull;
  always_ff @(posedge clk) begin
    if (skIn) skMem[skWr_q] <= rxWord;
  end
  always_ff @(posedge clk) begin
    if (rst || rxRst) begin
      skWr_q  <= 1'b0;
      skRd_q  <= 1'b0;
      skCnt_q <= 2'h0;
    end else begin
      skWr_q  <= skWr_q ^ skIn;
      skRd_q  <= skRd_q ^ skOut;
      skCnt_q <= skCnt_q + 2'(skIn) - 2'(skOut);
    end
  end

  utrbd_rx_s rxMem [RX_DEPTH];
  logic [RW-1:0] rxWr_q, rxRd_q;
  wire rxPop = rdHold && rxCnt_q != '0;
  wire rxNe = rxCnt_q != '0;
  utrbd_rx_s head;
  assign head = rxMem[rxRd_q];
  always_ff @(posedge clk) begin
    if (skOut) rxMem[rxWr_q] <= skMem[skRd_q];
  end
  always_ff @(posedge clk) begin
    if (rst || rxRst) begin
      rxWr_q  <= '0;
      rxRd_q  <= '0;
      rxCnt_q <= '0;
    end else begin
      if (skOut) rxWr_q <= rxWr_q + RW'(1);
      if (rxPop) rxRd_q <= rxRd_q + RW'(1);
      rxCnt_q <= rxCnt_q + (RW+1)'(skOut) - (RW+1)'(rxPop);
    end
  end

  // overrun sticks until status read; a new one wins over the clear
  wire ovrSet = rxStore && !skInReady;
  always_ff @(posedge clk) begin
    if (rst) ovr_q <= 1'b0;
    else ovr_q <= ovrSet || (ovr_q && !rdLsts);
  end

  // timeout: ticks for four words plus twelve bits
  wire [9:0] tmoLim = 10'((TMO_WORDS * (WL_BASE + int'(lctl_q[1:0]))
                      + TMO_BITS) * TICKS_PER_BIT - 1);
  logic [9:0] tmoCnt_q;
  always_ff @(posedge clk) begin
    if (rst || !rxNe || rxStore || rdHold) tmoCnt_q <= 10'h000;
    else if (tick && tmoCnt_q != tmoLim) tmoCnt_q <= tmoCnt_q + 10'h001;
  end
  wire tmoSet = fifoEn && rxNe && tick && tmoCnt_q == tmoLim - 10'h001;
  always_ff @(posedge clk) begin
    if (rst) tmo_q <= 1'b0;
    else tmo_q <= tmoSet || (tmo_q && !rdHold && rxNe);
  end

  // trigger level for data interrupt
  wire [RW:0] trigLvl = fctl_q[7:6] == 2'h0 ? (RW+1)'(1) :
                        fctl_q[7:6] == 2'h1 ? (RW+1)'(4) :
                        fctl_q[7:6] == 2'h2 ? (RW+1)'(8) : (RW+1)'(14);
  wire rxReady = fifoEn ? rxCnt_q >= trigLvl : rxNe;
  // gated by bit zero; transmit by bit one
  wire [3:0] srcCode = (ien_q[IEN_RXD] && tmo_q) ? SRC_TMO :
                       (ien_q[IEN_RXD] && rxReady) ? SRC_RXD :
                       (ien_q[IEN_THRE] && thre) ? SRC_THRE : SRC_NONE;
  // head tags shown in status bits two to four
  wire [7:0] lineSts = {1'b0, temt, thre, head.brk && rxNe,
                        head.frm && rxNe, head.par && rxNe, ovr_q, rxNe};
  wire [7:0] rdMux =
    addr == ADDR_HOLD ? (dlab ? div_q[7:0] : head.data) :
    addr == ADDR_IEN  ? (dlab ? div_q[15:8] : ien_q) :
    addr == ADDR_IFC  ? {fifoEn, fifoEn, 2'b00, srcCode} :
    addr == ADDR_LCTL ? lctl_q :
    addr == ADDR_LSTS ? lineSts : 8'h00;

  // registered outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      rdData_q <= 8'h00;
      txd_q    <= 1'b1;
      irq_q    <= 1'b0;
    end else begin
      if (rdStrobe) rdData_q <= rdMux;
      txd_q <= txLine;
      irq_q <= srcCode != SRC_NONE;
    end
  end
  assign rdData = rdData_q;
  assign txd = txd_q;
  assign irq = irq_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_load;
    txPop;
  endsequence
  a_idle_mark: assert property (
    (txState_q == TX_IDLE && !lctl_q[LCTL_BRK])[*2] |-> txd)
    else $error("line not high while idle");
  a_start_low: assert property (
    s_load ##1 !lctl_q[LCTL_BRK] |=> !txd)
    else $error("start bit not low");
  a_lsb_first: assert property (
    $rose(txState_q == TX_DATA) && !lctl_q[LCTL_BRK] |=> txd == txSh_q[0])
    else $error("first data bit not lsb");
  a_push_busy: assert property (
    txPush |=> !lineSts[5])
    else $error("holding empty after push");
  a_temt_load: assert property (
    s_load |=> !lineSts[6])
    else $error("empty flag while shifting");
  a_start_false: assert property (
    rxState_q == RX_START && rxSamp && rxS2_q |=> rxState_q == RX_IDLE)
    else $error("false start accepted");
  a_pop_step: assert property (
    rxPop && !rxRst |=> rxRd_q == $past(rxRd_q) + RW'(1))
    else $error("read did not advance fifo");
  a_rx_gate: assert property (
    !ien_q[IEN_RXD] |-> srcCode != SRC_RXD && srcCode != SRC_TMO)
    else $error("receive irq while disabled");
  a_thre_irq: assert property (
    ien_q[IEN_THRE] && thre |=> irq)
    else $error("transmit empty irq missing");
  a_tick_gap: assert property (
    tick && div_q > 16'h0001 && !wrDivL && !wrDivH |=> !tick)
    else $error("tick faster than divisor");
  a_ovr_set: assert property (
    ovrSet |=> ovr_q)
    else $error("overrun lost");
endmodule

//--- shared/utrbd_pkg.sv
package utrbd_pkg;
  // register offsets on the three-bit address
  localparam logic [2:0] ADDR_HOLD = 3'h0; // holding regs, divisor low
  localparam logic [2:0] ADDR_IEN  = 3'h1; // irq enable, divisor high
  localparam logic [2:0] ADDR_IFC  = 3'h2; // irq source rd, fifo ctl wr
  localparam logic [2:0] ADDR_LCTL = 3'h3;
  localparam logic [2:0] ADDR_LSTS = 3'h5;
  // values after reset
  localparam logic [7:0]  LCTL_RST = 8'h00;
  localparam logic [7:0]  IEN_RST  = 8'h00;
  localparam logic [7:0]  FCTL_RST = 8'h00;
  localparam logic [15:0] DIV_RST  = 16'h0001;
  // field positions
  localparam int LCTL_DLAB  = 7;
  localparam int LCTL_BRK   = 6;
  localparam int LCTL_STICK = 5;
  localparam int LCTL_EVEN  = 4;
  localparam int LCTL_PEN   = 3;
  localparam int LCTL_STOP  = 2;
  localparam int FCTL_EN    = 0;
  localparam int FCTL_RXRST = 1;
  localparam int FCTL_TXRST = 2;
  localparam int IEN_RXD    = 0;
  localparam int IEN_THRE   = 1;
  // cycle and tick counts
  localparam logic [3:0] BIT_LAST  = 4'hF; // 16 ticks per bit
  localparam logic [3:0] SAMPLE_AT = 4'h7; // eighth tick = bit centre
  localparam int TICKS_PER_BIT = 16;
  localparam int WL_BASE   = 5;
  localparam int TMO_WORDS = 4;
  localparam int TMO_BITS  = 12;
  // irq source codes
  localparam logic [3:0] SRC_NONE = 4'h1;
  localparam logic [3:0] SRC_THRE = 4'h2;
  localparam logic [3:0] SRC_RXD  = 4'h4;
  localparam logic [3:0] SRC_TMO  = 4'hC;
  // one receive fifo entry: three error tags and the byte
  typedef struct packed {
    logic       brk;
    logic       frm;
    logic       par;
    logic [7:0] data;
  } utrbd_rx_s;
  typedef enum logic [2:0] {
    TX_IDLE = 3'b000, TX_START = 3'b001, TX_DATA = 3'b010,
    TX_PAR = 3'b011, TX_STOP = 3'b100
  } utrbd_tx_e;
  typedef enum logic [2:0] {
    RX_IDLE = 3'b000, RX_START = 3'b001, RX_DATA = 3'b010,
    RX_PAR = 3'b011, RX_STOP = 3'b100
  } utrbd_rx_e;
endpackage

//--- verif/utrbd_serial_model.sv
`timescale 1ns/1ps
// far-end serial device: sends frames on rxd, captures frames on txd
module utrbd_serial_model (
  // bit timing reference
  input  wire logic clk,
  // serial lines seen from the far end
  input  wire logic txd,
  output logic      rxd
);
  int          bitCyc   = 32; // 16 ticks times divisor 2
  int          frameLen = 10;
  logic [11:0] capBits;
  logic [11:0] caps[$];

  initial rxd = 1'b1;

  // centre sampling of txd; rearms at stop centre so that
  // back-to-back characters are not missed
  always begin
    @(negedge txd);
    repeat (bitCyc / 2) @(posedge clk);
    capBits = '0;
    for (int i = 0; i < frameLen; i++) begin
      if (i > 0) repeat (bitCyc) @(posedge clk);
      capBits[i] = txd;
    end
    caps.push_back(capBits);
  end

  // bit time set by bitCyc, fixed to match divisor 2
  task automatic send(input logic [11:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      rxd = f[i];
      repeat (bitCyc) @(posedge clk);
      #1;
    end
    rxd = 1'b1;
    repeat (2 * bitCyc) @(posedge clk);
    #1;
  endtask

  // low pulse shorter than half a bit, a false start
  task automatic glitch(input int c);
    rxd = 1'b0;
    repeat (c) @(posedge clk);
    #1 rxd = 1'b1;
  endtask
endmodule

//--- verif/tb.sv
`timescale 1ns/1ps
module tb;
  import utrbd_pkg::*;
  logic        clk      = 1'b0;
  logic        rst      = 1'b1;
  logic [2:0]  addr     = 3'h0;
  logic        wrStrobe = 1'b0;
  logic        rdStrobe = 1'b0;
  logic [7:0]  wrData   = 8'h00;
  logic [7:0]  rdData;
  logic        txd;
  logic        irq;
  logic        rxd;
  int          error_cnt   = 0;
  int          check_count = 0;
  int          n;
  int          k;
  logic [7:0]  rv;
  logic [11:0] f;
  // ordinary transmit cases: line control beside the byte sent
  logic [7:0]  rowLc [6] = '{8'h03, 8'h00, 8'h19, 8'h0E, 8'h1F, 8'h07};
  logic [7:0]  rowDat[6] = '{8'hA5, 8'h13, 8'h2C, 8'h51, 8'hC3, 8'h80};

  always #2.5 clk = ~clk;

  utrbd_top utrbd_top_inst (.clk(clk), .rst(rst), .addr(addr),
    .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .wrData(wrData),
    .rdData(rdData), .rxd(rxd), .txd(txd), .irq(irq));
  utrbd_serial_model utrbd_serial_model_inst (.clk(clk), .txd(txd),
    .rxd(rxd));

  task automatic chk(input string nm, input logic [11:0] e,
                     input logic [11:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic close_out;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // register cycles: one-cycle strobes, inputs moved 1 ns after edge
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 addr = a; wrData = d; wrStrobe = 1'b1;
    @(posedge clk);
    #1 wrStrobe = 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    #1 addr = a; rdStrobe = 1'b1;
    @(posedge clk);
    #1 rdStrobe = 1'b0;
    @(posedge clk);
    #1 d = rdData;
  endtask
  // polls one line status bit under a bound
  task automatic wait_sts(input int b, input logic v);
    int j;
    j = 0;
    rd(ADDR_LSTS, rv);
    while (rv[b] !== v && j < 4000) begin
      rd(ADDR_LSTS, rv);
      j++;
    end
    chk("line status wait", {11'h0, v}, {11'h0, rv[b]});
  endtask

  // expected frame: start, data lsb first, parity, stop bits
  function automatic logic [11:0] mk(input logic [7:0] d,
    input logic [7:0] lc, input logic pflip, input logic stopv,
    output int cnt);
    logic [11:0] b;
    logic        p;
    b = '0;
    p = 1'b0;
    cnt = 1;
    for (int i = 0; i < 5 + int'(lc[1:0]); i++) begin
      b[cnt] = d[i];
      p = p ^ d[i];
      cnt++;
    end
    if (lc[LCTL_PEN]) begin
      b[cnt] = (lc[LCTL_EVEN] ? p : ~p) ^ pflip;
      cnt++;
    end
    b[cnt] = stopv;
    cnt++;
    if (lc[LCTL_STOP]) begin
      b[cnt] = 1'b1;
      cnt++;
    end
    return b;
  endfunction

  // one received character with its error tags
  task automatic rxc(input logic [7:0] d, input logic pflip,
                     input logic stopv, input logic [2:0] tags);
    f = mk(d, 8'h1B, pflip, stopv, n);
    utrbd_serial_model_inst.send(f, n);
    wait_sts(0, 1'b1);
    chk("rx tags", {9'h0, tags}, {9'h0, rv[4:2]});
    chk("rx data irq", 12'h1, {11'h0, irq});
    rd(ADDR_HOLD, rv);
    chk("rx data", {4'h0, d}, {4'h0, rv});
  endtask

  // watchdog, well beyond the expected sixteen thousand cycles
  initial begin
    repeat (80000) @(posedge clk);
    error_cnt++;
    close_out();
  end

  initial begin
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    chk("txd reset", 12'h1, {11'h0, txd});
    chk("irq reset", 12'h0, {11'h0, irq});
    rd(ADDR_LSTS, rv);
    chk("status reset", 12'h060, {4'h0, rv});
    rd(ADDR_IFC, rv);
    chk("source reset", {8'h0, SRC_NONE}, {4'h0, rv});
    rd(ADDR_LCTL, rv);
    chk("lctl reset", {4'h0, LCTL_RST}, {4'h0, rv});
    wr(ADDR_LCTL, 8'h80);
    wr(ADDR_HOLD, 8'h02);
    wr(ADDR_IEN, 8'h00);
    rd(ADDR_HOLD, rv);
    chk("divisor low", 12'h002, {4'h0, rv});
    rd(3'h4, rv);
    chk("unmapped", 12'h000, {4'h0, rv});
    for (int i = 0; i < 6; i++) begin
      wr(ADDR_LCTL, rowLc[i]);
      f = mk(rowDat[i], rowLc[i], 1'b0, 1'b1, n);
      utrbd_serial_model_inst.frameLen = n;
      wr(ADDR_HOLD, rowDat[i]);
      if (i == 0) begin
        @(negedge txd);
        k = 0;
        while (txd === 1'b0 && k < 100) begin
          @(posedge clk);
          #1 k++;
        end
        chk("start length", 12'd32, k[11:0]);
      end
      wait_sts(6, 1'b1);
      chk("tx frame", f, utrbd_serial_model_inst.caps.pop_front());
    end
    wr(ADDR_HOLD, 8'h3C);
    repeat (4) @(posedge clk);
    rd(ADDR_LSTS, rv);
    chk("holding to shifter", 12'h1, {10'h0, rv[6:5]});
    wait_sts(6, 1'b1);
    void'(utrbd_serial_model_inst.caps.pop_front());
    wr(ADDR_LCTL, 8'h1B);
    wr(ADDR_IEN, 8'h01);
    rxc(8'h5A, 1'b0, 1'b1, 3'b000);
    rxc(8'h5A, 1'b1, 1'b1, 3'b001);
    rxc(8'h3C, 1'b0, 1'b0, 3'b010);
    rxc(8'h00, 1'b0, 1'b0, 3'b110);
    utrbd_serial_model_inst.glitch(6);
    repeat (200) @(posedge clk);
    rd(ADDR_LSTS, rv);
    chk("false start", 12'h060, {4'h0, rv});
    wr(ADDR_IFC, 8'h01);
    f = mk(8'hA1, 8'h1B, 1'b0, 1'b1, n);
    utrbd_serial_model_inst.send(f, n);
    f = mk(8'hB2, 8'h1B, 1'b1, 1'b1, n);
    utrbd_serial_model_inst.send(f, n);
    f = mk(8'hC3, 8'h1B, 1'b0, 1'b1, n);
    utrbd_serial_model_inst.send(f, n);
    rd(ADDR_IFC, rv);
    chk("source rx data", 12'h0C4, {4'h0, rv});
    rd(ADDR_LSTS, rv);
    chk("head tags", 12'h001, {7'h0, rv[4:0]});
    rd(ADDR_HOLD, rv);
    chk("oldest first", 12'h0A1, {4'h0, rv});
    rd(ADDR_LSTS, rv);
    chk("next head tags", 12'h001, {9'h0, rv[4:2]});
    rd(ADDR_HOLD, rv);
    chk("second", 12'h0B2, {4'h0, rv});
    rd(ADDR_HOLD, rv);
    chk("third", 12'h0C3, {4'h0, rv});
    wr(ADDR_IFC, 8'h41);
    f = mk(8'h77, 8'h1B, 1'b0, 1'b1, n);
    utrbd_serial_model_inst.send(f, n);
    wait_sts(0, 1'b1);
    chk("below trigger", 12'h0, {11'h0, irq});
    k = 0;
    while (irq !== 1'b1 && k < 3000) begin
      @(posedge clk);
      #1 k++;
    end
    chk("timeout span", 12'h1, {11'h0, k >= 1200 && k <= 1420});
    rd(ADDR_IFC, rv);
    chk("source timeout", 12'h0CC, {4'h0, rv});
    rd(ADDR_HOLD, rv);
    repeat (2) @(posedge clk);
    chk("timeout clear", 12'h0, {11'h0, irq});
    wr(ADDR_IEN, 8'h00);
    f = mk(8'h66, 8'h1B, 1'b0, 1'b1, n);
    utrbd_serial_model_inst.send(f, n);
    repeat (1600) @(posedge clk);
    chk("masked rx irq", 12'h0, {11'h0, irq});
    rd(ADDR_HOLD, rv);
    wr(ADDR_IEN, 8'h02);
    repeat (2) @(posedge clk);
    chk("tx empty irq", 12'h1, {11'h0, irq});
    rd(ADDR_IFC, rv);
    chk("source tx empty", 12'h0C2, {4'h0, rv});
    wr(ADDR_IEN, 8'h00);
    utrbd_serial_model_inst.frameLen = 11;
    for (int i = 0; i < 20; i++) wr(ADDR_HOLD, 8'(i));
    rd(ADDR_LSTS, rv);
    chk("fifo busy", 12'h0, {10'h0, rv[6:5]});
    wait_sts(5, 1'b1);
    chk("shifter busy", 12'h0, {11'h0, rv[6]});
    wait_sts(6, 1'b1);
    k = utrbd_serial_model_inst.caps.size();
    chk("fifo capacity", 12'h1, {11'h0, k >= 17 && k <= 19});
    for (int i = 0; i < k; i++) begin
      f = mk(8'(i), 8'h1B, 1'b0, 1'b1, n);
      chk("fifo frame", f, utrbd_serial_model_inst.caps[i]);
    end
    close_out();
  end
endmodule
